// ---- logic/ooc_pkg.sv ----
// package: constants and register map of the on/off controller output stage
package ooc_pkg;

  localparam int unsigned ADDR_W      = 4;
  localparam int unsigned DATA_W      = 32;
  localparam int unsigned TEMP_W      = 16;
  localparam int unsigned AUX_N       = 4;
  localparam int unsigned SP_SLOTS    = 8;
  localparam int unsigned SLOT_W      = 3;
  localparam int unsigned PROT_W      = 2;
  localparam int unsigned CNT_W       = 32;

  // timing: figures in seconds, clock in hertz
  localparam int unsigned CLK_HZ       = 100_000_000;
  localparam int unsigned SP_COMMIT_S  = 3;
  localparam int unsigned POWERUP_S    = 2;
  localparam int unsigned SP_COMMIT_CYC = SP_COMMIT_S * CLK_HZ;
  localparam int unsigned POWERUP_CYC   = POWERUP_S * CLK_HZ;

  // register word addresses
  localparam logic [ADDR_W-1:0] REG_CTRL     = 4'h0;
  localparam logic [ADDR_W-1:0] REG_PROTECT  = 4'h1;
  localparam logic [ADDR_W-1:0] REG_SP_EDIT  = 4'h2;
  localparam logic [ADDR_W-1:0] REG_SP_SAVE  = 4'h3;
  localparam logic [ADDR_W-1:0] REG_HYS_HEAT = 4'h4;
  localparam logic [ADDR_W-1:0] REG_HYS_COOL = 4'h5;
  localparam logic [ADDR_W-1:0] REG_SP_ACT   = 4'h6;
  localparam logic [ADDR_W-1:0] REG_STATUS   = 4'h7;

  // control register fields
  localparam int unsigned CTRL_PID_BIT    = 0;
  localparam int unsigned CTRL_DIRECT_BIT = 1;
  localparam int unsigned CTRL_HC_BIT     = 2;
  localparam int unsigned CTRL_POL_LSB    = 4;
  localparam int unsigned CTRL_SEL_LSB    = 8;

  // status register fields
  localparam int unsigned ST_HEAT_BIT  = 0;
  localparam int unsigned ST_COOL_BIT  = 1;
  localparam int unsigned ST_PEND_BIT  = 2;
  localparam int unsigned ST_FORCE_BIT = 3;
  localparam int unsigned ST_AUX_LSB   = 4;

  localparam logic [PROT_W-1:0] PROT_LOCK_SP = 2'h3;
  localparam logic [TEMP_W-1:0] SP_RESET     = 16'h0000;
  localparam logic [TEMP_W-1:0] HYS_RESET    = 16'h000a;
  localparam logic [AUX_N-1:0]  POL_RESET    = 4'h0;

  typedef enum logic [1:0] {
    OOC_OUT_OFF_TYPE_HOLD = 2'b00,
    OOC_OUT_ON            = 2'b01,
    OOC_OUT_OFF           = 2'b10
  } ooc_switch_type;

endpackage

// ---- logic/ooc_sp_mem.sv ----
// memory of the eight stored set points with registered read data
`timescale 1ns/1ns
`default_nettype none
module ooc_sp_mem
  import ooc_pkg::*;
(
  input  wire logic                clk_i,
  input  wire logic                rst_n_i,
  input  wire logic                wr_i,
  input  wire logic [SLOT_W-1:0]   wr_slot_i,
  input  wire logic [TEMP_W-1:0]   wr_data_i,
  input  wire logic [SLOT_W-1:0]   rd_slot_i,
  output logic      [TEMP_W-1:0]   rd_data_o
);
  logic [TEMP_W-1:0] mem_q [SP_SLOTS];

  // every slot starts at zero degrees
  genvar g;
  generate
    for (g = 0; g < SP_SLOTS; g++) begin : g_slot
      always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
          mem_q[g] <= SP_RESET;
        end else if (wr_i && (wr_slot_i == SLOT_W'(g))) begin
          mem_q[g] <= wr_data_i;
        end
      end
    end
  endgenerate

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rd_data_o <= SP_RESET;
    end else begin
      rd_data_o <= mem_q[rd_slot_i];
    end
  end
endmodule
`default_nettype wire

// ---- logic/ooc_top.sv ----
// on/off controller output stage: set point entry, on/off control, alarm polarity
`timescale 1ns/1ns
`default_nettype none
module ooc_top
  import ooc_pkg::*;
#(
  parameter int unsigned COMMIT_CYC  = SP_COMMIT_CYC,
  parameter int unsigned POWERUP_LEN = POWERUP_CYC
) (
  input  wire logic                    mclk_i,
  input  wire logic                    rst_n_i,
  input  wire logic [ooc_pkg::ADDR_W-1:0] addr_i,
  input  wire logic [ooc_pkg::DATA_W-1:0] wdata_i,
  input  wire logic                    wr_i,
  input  wire logic                    rd_i,
  output logic      [ooc_pkg::DATA_W-1:0] rdata_o,
  input  wire logic [ooc_pkg::TEMP_W-1:0] pv_i,
  input  wire logic [ooc_pkg::AUX_N-1:0]  aux_func_i,
  output logic      [ooc_pkg::AUX_N-1:0]  aux_pin_o,
  output logic      [ooc_pkg::AUX_N-1:0]  aux_output_indicators_o,
  output logic                         ctrl_heat_o,
  output logic                         ctrl_cool_o,
  output logic                         pid_active_o
);
  import ooc_pkg::*;

  // ==========================================================
  // reset release
  logic rst_meta_q;
  logic rst_q;
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rst_meta_q <= 1'b0;
      rst_q      <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_q      <= rst_meta_q;
    end
  end

  // ==========================================================
  // register decode
  wire wr_ctrl  = wr_i && (addr_i == REG_CTRL);
  wire wr_prot  = wr_i && (addr_i == REG_PROTECT);
  wire wr_edit  = wr_i && (addr_i == REG_SP_EDIT);
  wire wr_save  = wr_i && (addr_i == REG_SP_SAVE);
  wire wr_hysh  = wr_i && (addr_i == REG_HYS_HEAT);
  wire wr_hysc  = wr_i && (addr_i == REG_HYS_COOL);

  logic              pid_q;
  logic              direct_q;
  logic              hc_q;
  logic [AUX_N-1:0]  pol_q;
  logic [SLOT_W-1:0] sel_q;
  logic [PROT_W-1:0] prot_q;
  logic [TEMP_W-1:0] hys_heat_q;
  logic [TEMP_W-1:0] hys_cool_q;

  always_ff @(posedge mclk_i or negedge rst_q) begin
    if (!rst_q) begin
      pid_q      <= 1'b0;
      direct_q   <= 1'b0;
      hc_q       <= 1'b0;
      pol_q      <= POL_RESET;
      sel_q      <= '0;
      prot_q     <= '0;
      hys_heat_q <= HYS_RESET;
      hys_cool_q <= HYS_RESET;
    end else begin
      if (wr_ctrl) begin
        pid_q    <= wdata_i[CTRL_PID_BIT];
        direct_q <= wdata_i[CTRL_DIRECT_BIT];
        hc_q     <= wdata_i[CTRL_HC_BIT];
        pol_q    <= wdata_i[CTRL_POL_LSB +: AUX_N];
        sel_q    <= wdata_i[CTRL_SEL_LSB +: SLOT_W];
      end
      if (wr_prot) begin
        prot_q <= wdata_i[PROT_W-1:0];
      end
      if (wr_hysh) begin
        hys_heat_q <= wdata_i[TEMP_W-1:0];
      end
      if (wr_hysc) begin
        hys_cool_q <= wdata_i[TEMP_W-1:0];
      end
    end
  end

  // ==========================================================
  // set point entry
  wire sp_locked = (prot_q == PROT_LOCK_SP);
  wire edit_ok   = wr_edit && !sp_locked;

  logic              pend_q;
  logic [TEMP_W-1:0] edit_q;
  logic [CNT_W-1:0]  hold_q;

  wire hold_done = pend_q && (hold_q == CNT_W'(COMMIT_CYC - 1));
  // a new edit restarts the wait instead of committing the old value
  wire commit    = pend_q && !edit_ok && (wr_save || hold_done);

  always_ff @(posedge mclk_i or negedge rst_q) begin
    if (!rst_q) begin
      pend_q <= 1'b0;
      edit_q <= SP_RESET;
      hold_q <= '0;
    end else if (edit_ok) begin
      pend_q <= 1'b1;
      edit_q <= wdata_i[TEMP_W-1:0];
      hold_q <= '0;
    end else if (commit) begin
      pend_q <= 1'b0;
      hold_q <= '0;
    end else if (pend_q) begin
      hold_q <= hold_q + CNT_W'(1);
    end
  end

  logic [TEMP_W-1:0] sp_act;
  ooc_sp_mem u_mem (
    .clk_i     (mclk_i),
    .rst_n_i   (rst_q),
    .wr_i      (commit),
    .wr_slot_i (sel_q),
    .wr_data_i (edit_q),
    .rd_slot_i (sel_q),
    .rd_data_o (sp_act)
  );

  // ==========================================================
  // on/off control
  wire signed [TEMP_W:0] pv_x  = {pv_i[TEMP_W-1], pv_i};
  wire signed [TEMP_W:0] sp_x  = {sp_act[TEMP_W-1], sp_act};
  wire signed [TEMP_W:0] hh_x  = {1'b0, hys_heat_q};
  wire signed [TEMP_W:0] hc_x  = {1'b0, hys_cool_q};
  // standard control takes the heating hysteresis either way
  wire signed [TEMP_W:0] h1_x  = hh_x;
  wire signed [TEMP_W:0] h2_x  = hc_q ? hc_x : hh_x;

  // reverse: off at sp, on below sp - hys; direct mirrors it
  wire rev_off  = pv_x >= sp_x;
  wire rev_on   = pv_x < (sp_x - h1_x);
  wire dir_off  = pv_x <= sp_x;
  wire dir_on   = pv_x > (sp_x + h2_x);

  // heating/cooling mode: output 1 always reverse, output 2 direct
  wire o1_rev   = hc_q ? 1'b1 : !direct_q;
  wire o1_on    = o1_rev ? rev_on : dir_on;
  wire o1_off   = o1_rev ? rev_off : dir_off;

  logic heat_q;
  logic cool_q;
  always_ff @(posedge mclk_i or negedge rst_q) begin
    if (!rst_q) begin
      heat_q <= 1'b0;
      cool_q <= 1'b0;
    end else if (pid_q) begin
      // pid arithmetic lives elsewhere; on/off drive is parked
      heat_q <= 1'b0;
      cool_q <= 1'b0;
    end else begin
      if (o1_off) begin
        heat_q <= 1'b0;
      end else if (o1_on) begin
        heat_q <= 1'b1;
      end
      if (!hc_q || dir_off) begin
        cool_q <= 1'b0;
      end else if (dir_on) begin
        cool_q <= 1'b1;
      end
    end
  end
  assign ctrl_heat_o  = heat_q;
  assign ctrl_cool_o  = cool_q;
  assign pid_active_o = pid_q;

  // ==========================================================
  // auxiliary outputs
  logic [CNT_W-1:0] pwr_q;
  wire              forcing = (pwr_q != CNT_W'(POWERUP_LEN));
  always_ff @(posedge mclk_i or negedge rst_q) begin
    if (!rst_q) begin
      pwr_q <= '0;
    end else if (forcing) begin
      pwr_q <= pwr_q + CNT_W'(1);
    end
  end

  logic [AUX_N-1:0] pin_q;
  logic [AUX_N-1:0] ind_q;
  genvar a;
  generate
    for (a = 0; a < AUX_N; a++) begin : g_aux
      wire drive = aux_func_i[a] ^ pol_q[a];
      always_ff @(posedge mclk_i or negedge rst_q) begin
        if (!rst_q) begin
          pin_q[a] <= 1'b0;
          ind_q[a] <= 1'b0;
        end else begin
          pin_q[a] <= drive && !forcing;
          ind_q[a] <= aux_func_i[a];
        end
      end
    end
  endgenerate
  assign aux_pin_o               = pin_q;
  assign aux_output_indicators_o = ind_q;

  // ==========================================================
  // read port
  logic [DATA_W-1:0] rsel;
  always_comb begin
    rsel = '0;
    unique case (addr_i)
      REG_CTRL: begin
        rsel[CTRL_PID_BIT]             = pid_q;
        rsel[CTRL_DIRECT_BIT]          = direct_q;
        rsel[CTRL_HC_BIT]              = hc_q;
        rsel[CTRL_POL_LSB +: AUX_N]    = pol_q;
        rsel[CTRL_SEL_LSB +: SLOT_W]   = sel_q;
      end
      REG_PROTECT:  rsel[PROT_W-1:0] = prot_q;
      REG_SP_EDIT:  rsel[TEMP_W-1:0] = edit_q;
      REG_HYS_HEAT: rsel[TEMP_W-1:0] = hys_heat_q;
      REG_HYS_COOL: rsel[TEMP_W-1:0] = hys_cool_q;
      REG_SP_ACT:   rsel[TEMP_W-1:0] = sp_act;
      REG_STATUS: begin
        rsel[ST_HEAT_BIT]            = heat_q;
        rsel[ST_COOL_BIT]            = cool_q;
        rsel[ST_PEND_BIT]            = pend_q;
        rsel[ST_FORCE_BIT]           = forcing;
        rsel[ST_AUX_LSB +: AUX_N]    = pin_q;
      end
      default: rsel = '0;
    endcase
  end

  logic [DATA_W-1:0] rdata_q;
  always_ff @(posedge mclk_i or negedge rst_q) begin
    if (!rst_q) begin
      rdata_q <= '0;
    end else begin
      rdata_q <= rd_i ? rsel : '0;
    end
  end
  assign rdata_o = rdata_q;

  // ==========================================================
  // checks
  property p_pol_close;
    @(posedge mclk_i) disable iff (!rst_q)
      (!forcing && !pol_q[0]) |=> (aux_pin_o[0] == $past(aux_func_i[0]));
  endproperty
  a_pol_close: assert property (p_pol_close) else $error("close polarity wrong");

  property p_pol_open;
    @(posedge mclk_i) disable iff (!rst_q)
      (!forcing && pol_q[1]) |=> (aux_pin_o[1] != $past(aux_func_i[1]));
  endproperty
  a_pol_open: assert property (p_pol_open) else $error("open polarity wrong");

  property p_pol_own;
    @(posedge mclk_i) disable iff (!rst_q)
      (!forcing && (pol_q[2] != pol_q[3]) && (aux_func_i[2] == aux_func_i[3]))
        |=> (aux_pin_o[2] != aux_pin_o[3]);
  endproperty
  a_pol_own: assert property (p_pol_own) else $error("polarity leaks");

  property p_force_off;
    @(posedge mclk_i) disable iff (!rst_q)
      forcing |=> (aux_pin_o == '0);
  endproperty
  a_force_off: assert property (p_force_off) else $error("alarm pin on at power-up");

  property p_lock;
    @(posedge mclk_i) disable iff (!rst_q)
      // a running wait may still time out beside a refused edit
      (wr_edit && sp_locked) |=> ($stable(edit_q) && !$rose(pend_q));
  endproperty
  a_lock: assert property (p_lock) else $error("locked set point edited");

  property p_timeout;
    @(posedge mclk_i) disable iff (!rst_q)
      (pend_q && !wr_i && (hold_q == CNT_W'(COMMIT_CYC - 1))) |=> !pend_q;
  endproperty
  a_timeout: assert property (p_timeout) else $error("no commit after wait");

  property p_save;
    @(posedge mclk_i) disable iff (!rst_q)
      (pend_q && wr_save) |=> (!pend_q ##1 (sp_act == $past(edit_q, 2)));
  endproperty
  a_save: assert property (p_save) else $error("save did not commit");

  property p_heat_off;
    @(posedge mclk_i) disable iff (!rst_q)
      (!pid_q && !hc_q && !direct_q && (pv_x >= sp_x)) |=> !ctrl_heat_o;
  endproperty
  a_heat_off: assert property (p_heat_off) else $error("heat on at set point");

  property p_hys;
    @(posedge mclk_i) disable iff (!rst_q)
      (!pid_q && !hc_q && !direct_q && !ctrl_heat_o && (pv_x >= sp_x - hh_x))
        |=> !ctrl_heat_o;
  endproperty
  a_hys: assert property (p_hys) else $error("heat on inside band");

  property p_pid;
    @(posedge mclk_i) disable iff (!rst_q)
      (pid_q && !wr_ctrl) |=> (!ctrl_heat_o && !ctrl_cool_o && pid_active_o);
  endproperty
  a_pid: assert property (p_pid) else $error("on/off drive in pid mode");

  property p_direct;
    @(posedge mclk_i) disable iff (!rst_q)
      (!pid_q && !hc_q && direct_q && (pv_x > sp_x + hh_x)) |=> ctrl_heat_o;
  endproperty
  a_direct: assert property (p_direct) else $error("direct action not on");

endmodule
`default_nettype wire

// ---- testbench/ooc_plant.sv ----
// far-side model: process value and alarm function sources
`timescale 1ns/1ns
`default_nettype none
module ooc_plant
  import ooc_pkg::*;
(
  input  wire logic              clk_i,
  output logic      [TEMP_W-1:0] pv_o,
  output logic      [AUX_N-1:0]  aux_o
);
  initial begin
    pv_o  = '0;
    aux_o = '0;
  end

  // values move just after a rising edge so the design samples them a full cycle later
  task automatic set_pv(input logic [TEMP_W-1:0] v);
    @(posedge clk_i);
    pv_o <= v;
  endtask

  task automatic set_aux(input logic [AUX_N-1:0] v);
    @(posedge clk_i);
    aux_o <= v;
  endtask
endmodule
`default_nettype wire

// ---- testbench/tb_onoff_control_alarm_polarity.sv ----
// self-checking bench for the on/off controller output stage
`timescale 1ns/1ns
`default_nettype none
module tb_onoff_control_alarm_polarity;
  import ooc_pkg::*;
  localparam int unsigned CMT = 20;
  localparam int unsigned PUP = 10;

  logic                mclk_i;
  logic                rst_n_i;
  logic [ADDR_W-1:0]   addr_i;
  logic [DATA_W-1:0]   wdata_i;
  logic                wr_i;
  logic                rd_i;
  logic [DATA_W-1:0]   rdata_o;
  logic [TEMP_W-1:0]   pv;
  logic [AUX_N-1:0]    aux_func;
  logic [AUX_N-1:0]    aux_pin_o;
  logic [AUX_N-1:0]    ind_o;
  logic                ctrl_heat_o;
  logic                ctrl_cool_o;
  logic                pid_active_o;
  int                  n_errors;
  int                  total_checks;

  ooc_top #(.COMMIT_CYC(CMT), .POWERUP_LEN(PUP)) ooc_top_i (
    .mclk_i(mclk_i), .rst_n_i(rst_n_i), .addr_i(addr_i), .wdata_i(wdata_i),
    .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .pv_i(pv), .aux_func_i(aux_func),
    .aux_pin_o(aux_pin_o), .aux_output_indicators_o(ind_o),
    .ctrl_heat_o(ctrl_heat_o), .ctrl_cool_o(ctrl_cool_o), .pid_active_o(pid_active_o)
  );

  ooc_plant ooc_plant_i (.clk_i(mclk_i), .pv_o(pv), .aux_o(aux_func));

  // ==========================================================
  // bus and compare tasks
  initial begin
    mclk_i = 1'b0;
    forever #5 mclk_i = ~mclk_i;
  end

  task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    @(posedge mclk_i);
    addr_i  <= a;
    wdata_i <= d;
    wr_i    <= 1'b1;
    @(posedge mclk_i);
    wr_i    <= 1'b0;
  endtask

  // read data stand only in the cycle after the strobe, so sample just past that edge
  task automatic rd(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] d);
    @(posedge mclk_i);
    addr_i <= a;
    rd_i   <= 1'b1;
    @(posedge mclk_i);
    rd_i   <= 1'b0;
    #1;
    d = rdata_o;
  endtask

  task automatic chk(input logic [DATA_W-1:0] got, input logic [DATA_W-1:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic chk_rd(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] exp);
    logic [DATA_W-1:0] d;
    rd(a, d);
    chk(d, exp);
  endtask

  task automatic wait_cyc(input int n);
    repeat (n) @(posedge mclk_i);
    #1;
  endtask

  // pv step, then outputs {cool, heat} after they settle
  task automatic pv_chk(input logic [TEMP_W-1:0] v, input logic [1:0] exp);
    ooc_plant_i.set_pv(v);
    wait_cyc(3);
    chk({30'h0, ctrl_cool_o, ctrl_heat_o}, {30'h0, exp});
  endtask

  task automatic results;
    $display("checks=%0d errors=%0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  initial begin
    #200000;
    n_errors++;
    results;
  end

  // ==========================================================
  // tests
  initial begin
    n_errors = 0;
    total_checks = 0;
    rst_n_i = 1'b0;
    addr_i = '0;
    wdata_i = '0;
    wr_i = 1'b0;
    rd_i = 1'b0;
    ooc_plant_i.set_aux(4'hf);
    // set_aux above already used the first of the ten reset cycles
    repeat (9) @(posedge mclk_i);
    rst_n_i <= 1'b1;
    wait_cyc(5);
    chk({28'h0, aux_pin_o}, 32'h0);
    chk({28'h0, ind_o}, 32'hf);
    wait_cyc(PUP + 5);
    chk({28'h0, aux_pin_o}, 32'hf);
    chk_rd(REG_SP_ACT, 32'h0);
    chk_rd(REG_CTRL, 32'h0);
    chk_rd(REG_HYS_HEAT, 32'h0000000a);
    $display("test reset done");

    wr(REG_CTRL, 32'h00000050);
    ooc_plant_i.set_aux(4'h3);
    wait_cyc(3);
    chk({28'h0, aux_pin_o}, 32'h6);
    chk({28'h0, ind_o}, 32'h3);
    wr(REG_CTRL, 32'h0);
    wait_cyc(3);
    chk({28'h0, aux_pin_o}, 32'h3);
    $display("test polarity done");

    wr(REG_PROTECT, 32'h3);
    wr(REG_SP_EDIT, 32'h00000032);
    wr(REG_SP_SAVE, 32'h1);
    wait_cyc(CMT + 5);
    chk_rd(REG_SP_ACT, 32'h0);
    wr(REG_PROTECT, 32'h0);
    wr(REG_SP_EDIT, 32'h000000c8);
    wr(REG_SP_SAVE, 32'h1);
    wait_cyc(3);
    chk_rd(REG_SP_ACT, 32'h000000c8);
    wr(REG_SP_EDIT, 32'h00000064);
    // pv still 0, far below sp 200 minus hysteresis, so heating is on
    chk_rd(REG_STATUS, 32'h00000035);
    wait_cyc(CMT - 8);
    chk_rd(REG_SP_ACT, 32'h000000c8);
    wait_cyc(6);
    chk_rd(REG_SP_ACT, 32'h00000064);
    $display("test set point done");

    wr(REG_CTRL, 32'h00000100);
    wait_cyc(3);
    chk_rd(REG_SP_ACT, 32'h0);
    wr(REG_SP_EDIT, 32'h0000012c);
    wr(REG_SP_SAVE, 32'h1);
    wait_cyc(3);
    chk_rd(REG_SP_ACT, 32'h0000012c);
    wr(REG_CTRL, 32'h0);
    wait_cyc(3);
    chk_rd(REG_SP_ACT, 32'h00000064);
    chk_rd(4'h9, 32'h0);
    $display("test multi slot done");

    wr(REG_SP_EDIT, 32'h000000c8);
    wr(REG_SP_SAVE, 32'h1);
    wr(REG_HYS_COOL, 32'h5);
    pv_chk(16'd189, 2'b01);
    pv_chk(16'd195, 2'b01);
    pv_chk(16'd200, 2'b00);
    pv_chk(16'd195, 2'b00);
    wr(REG_CTRL, 32'h2);
    pv_chk(16'd210, 2'b00);
    pv_chk(16'd211, 2'b01);
    pv_chk(16'd205, 2'b01);
    pv_chk(16'd200, 2'b00);
    wr(REG_CTRL, 32'h4);
    pv_chk(16'd206, 2'b10);
    pv_chk(16'd200, 2'b00);
    pv_chk(16'd189, 2'b01);
    wr(REG_CTRL, 32'h1);
    wait_cyc(3);
    chk({30'h0, pid_active_o, ctrl_heat_o}, 32'h2);
    $display("test on off done");
    results;
  end
endmodule
`default_nettype wire
